// ### sim/edge_watchdog_clock_select_bench.sv
// Purpose : self-checking bench for ewcs_top
// Assumes : 100 MHz clock, classic wishbone master
// Notes   : inputs change by non-blocking assignment at rising edges
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module edge_watchdog_clock_select_bench;
  logic clock, rst_n, cyc, stb, we, sleep, pin, ack, ereq, wdt, irq, sor, srr, wcs;
  logic [3:0] adr, sel, n;
  logic [31:0] wdat, rdat, q;
  logic [1:0] frf;
  ewcs_pkg::ewcs_cfg_s cfg;
  ewcs_pkg::ewcs_pins_s pins;
  int failures, n_compared;
  ewcs_top dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cfg(cfg), .sleep(sleep), .ext_irq_pin(pin), .ext_irq_req(ereq), .watchdog_run(wdt),
    .irq(irq), .osc_pins(pins), .sys_osc_run(sor), .slow_rc_run(srr), .wdt_clk_slow(wcs),
    .fast_rc_freq(frf));
  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #200000;
    failures++;
    test_done();
  end
  // one wishbone access, held until ack is seen at a rising edge; data taken there
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(negedge clock);
  endtask
  // toggle the pin and count requests
  task automatic pulse(input logic v);
    @(posedge clock);
    pin <= v;
    n = 4'h0;
    repeat (10) @(negedge clock) n += {3'h0, ereq};
  endtask
  task automatic t_reset();
    acc(1'b0, ewcs_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0000_008a, q)
    `CHK("wdt reset", 1'b0, wdt)
    acc(1'b0, 4'h2, 32'h0);
    `CHK("unmapped", 32'h0, q)
  endtask
  task automatic t_edge();
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, ewcs_pkg::ADDR_CTRL, {24'h0, s[1:0], 6'h0a});
      pulse(1'b1);
      `CHK("rise", {3'h0, s[0]}, n)
      pulse(1'b0);
      `CHK("fall", {3'h0, s[1]}, n)
    end
    `CHK("irq masked", 1'b0, irq)
    acc(1'b1, ewcs_pkg::ADDR_IRQ_MK, 32'h1);
    `CHK("irq on", 1'b1, irq)
    acc(1'b1, ewcs_pkg::ADDR_IRQ_ST, 32'h3);
    `CHK("irq cleared", 1'b0, irq)
  endtask
  // reset again in mid-run after changing the control register
  task automatic t_rst_mid();
    acc(1'b1, ewcs_pkg::ADDR_CTRL, 32'h45);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    acc(1'b0, ewcs_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl rerun", 32'h0000_008a, q)
    `CHK("wdt rerun", 1'b0, wdt)
  endtask
  task automatic t_wdt();
    acc(1'b1, ewcs_pkg::ADDR_CTRL, 32'hff);
    acc(1'b0, ewcs_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl rsvd", 32'h0000_00cf, q)
    `CHK("wdt on", 1'b1, wdt)
    acc(1'b1, ewcs_pkg::ADDR_CTRL, 32'h8a);
    `CHK("wdt off", 1'b0, wdt)
    acc(1'b1, ewcs_pkg::ADDR_CTRL, 32'h85);
    `CHK("wdt rec", 1'b1, wdt)
    acc(1'b1, ewcs_pkg::ADDR_CTRL, 32'h8a);
    @(posedge clock);
    cfg.wdt_force_on <= 1'b1;
    repeat (3) @(negedge clock);
    `CHK("wdt forced", 1'b1, wdt)
    acc(1'b0, ewcs_pkg::ADDR_IRQ_ST, 32'h0);
    `CHK("status wdt", 32'h0000_0002, q)
  endtask
  task automatic t_clk();
    for (int s = 0; s < 4; s++) begin
      for (int f = 0; f < 3; f++) begin
        @(posedge clock);
        cfg.clk_src      <= ewcs_pkg::ewcs_src_e'(s[1:0]);
        cfg.fast_rc_freq <= ewcs_pkg::ewcs_frc_e'(f[1:0]);
        {cfg.slow_rc_off, cfg.wdt_from_sysclk, sleep} <= {f[0], s[0], f[1]};
        acc(1'b0, ewcs_pkg::ADDR_CFG, 32'h0);
        `CHK("cfg mirror", {25'h0, s[0], f[0], 1'b1, f[1:0], s[1:0]}, q)
        if (s < 3) `CHK("pins", {s < 2, s == 0}, pins)
        `CHK("frc", (s == 2) ? f[1:0] : 2'h0, frf)
        `CHK("sysosc", ~f[1], sor)
        `CHK("slowrc", ~f[0], srr)
        `CHK("wdtclk", ~f[0] & ~s[0], wcs)
      end
    end
  endtask
  task automatic test_done();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // reset then scenarios
  initial begin
    {rst_n, cyc, stb, we, sleep, pin, adr, wdat, cfg} = '0;
    sel = 4'hf;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_edge();
    t_rst_mid();
    t_wdt();
    t_clk();
    test_done();
  end
endmodule // edge_watchdog_clock_select_bench
`default_nettype wire

// ### sim/ewcs_top_props.sv
// Purpose : port-level checks for ewcs_top
// Assumes : one clock, synchronous active-low reset
// Notes   : attached by the bind below
`timescale 1ns/100ps
`default_nettype none
module ewcs_top_props (
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic [3:0]           wb_adr_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire ewcs_pkg::ewcs_cfg_s  cfg,
  input wire logic                 sleep,
  input wire logic                 ext_irq_req,
  input wire logic                 watchdog_run,
  input wire ewcs_pkg::ewcs_pins_s osc_pins,
  input wire logic                 sys_osc_run,
  input wire logic                 slow_rc_run,
  input wire logic                 wdt_clk_slow,
  input wire logic [1:0]           fast_rc_freq
);
  // --------------------------------------------------------------
  // bus, watchdog, clock and edge request checks
  // --------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  AST_CTRL_RSVD: assert property (
    wb_ack_o && wb_adr_i == ewcs_pkg::ADDR_CTRL |-> wb_dat_o[5:4] == 2'h0)
    else $error("control bits 5:4 not zero");
  AST_WDT_FORCE: assert property (
    $past(rst_n) && cfg.wdt_force_on |=> watchdog_run) else $error("forced watchdog off");
  AST_OSC_PINS: assert property (
    cfg.clk_src != ewcs_pkg::EWCS_SRC_SLOW_RC |-> osc_pins == {cfg.clk_src <= 2'h1,
    cfg.clk_src == ewcs_pkg::EWCS_SRC_CRYSTAL}) else $error("oscillator pin claim wrong");
  AST_FRC_FREQ: assert property (
    cfg.clk_src == ewcs_pkg::EWCS_SRC_FAST_RC |-> fast_rc_freq == cfg.fast_rc_freq)
    else $error("fast rc frequency wrong");
  AST_SLEEP_CLK: assert property (
    sys_osc_run == !sleep && !(cfg.slow_rc_off && slow_rc_run)) else $error("sleep clocks");
  AST_WDT_CLK: assert property (
    wdt_clk_slow == (!cfg.wdt_from_sysclk && !cfg.slow_rc_off)) else $error("wdt clock");
  AST_EDGE_PULSE: assert property (ext_irq_req |=> !ext_irq_req)
    else $error("edge request longer than a cycle");
endmodule // ewcs_top_props
bind ewcs_top ewcs_top_props u_props (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cfg(cfg), .sleep(sleep), .ext_irq_req(ext_irq_req), .watchdog_run(watchdog_run),
  .osc_pins(osc_pins), .sys_osc_run(sys_osc_run), .slow_rc_run(slow_rc_run),
  .wdt_clk_slow(wdt_clk_slow), .fast_rc_freq(fast_rc_freq));
`default_nettype wire

// ### src/ewcs_clock_select.sv
// Purpose : decode clock-source options into pin ownership and oscillator enables
// Assumes : options are static straps
// Notes   : purely combinational
`timescale 1ns/100ps
`default_nettype none
module ewcs_clock_select (
  input  wire ewcs_pkg::ewcs_cfg_s  cfg,
  input  wire logic                 sleep,
  input  wire logic                 wdt_on,
  output ewcs_pkg::ewcs_pins_s      pins,
  output logic                      sys_osc_run,
  output logic                      slow_rc_run,
  output logic                      wdt_clk_slow,
  output logic [1:0]                fast_rc_freq
);

  // pin ownership per source
  always_comb begin
    pins = '0;
    unique case (cfg.clk_src)
      ewcs_pkg::EWCS_SRC_CRYSTAL: begin
        pins.osc_pin_one_claimed = 1'b1;
        pins.osc_pin_two_claimed = 1'b1;
      end
      ewcs_pkg::EWCS_SRC_EXT_RC: pins.osc_pin_one_claimed = 1'b1;
      ewcs_pkg::EWCS_SRC_FAST_RC: pins = '0;
      ewcs_pkg::EWCS_SRC_SLOW_RC: pins = '0;
    endcase
  end

  // system clock stops in sleep; slow rc runs when it is the source or the watchdog is on, unless option turns it off
  assign sys_osc_run  = !sleep;
  assign slow_rc_run  = !cfg.slow_rc_off &&
                        (cfg.clk_src == ewcs_pkg::EWCS_SRC_SLOW_RC || wdt_on);
  // watchdog clocked from slow rc unless it follows the system clock or option turns slow rc off
  assign wdt_clk_slow = !cfg.wdt_from_sysclk && !cfg.slow_rc_off;
  assign fast_rc_freq = (cfg.clk_src == ewcs_pkg::EWCS_SRC_FAST_RC) ?
                        cfg.fast_rc_freq : 2'h0;

endmodule // ewcs_clock_select
`default_nettype wire

// ### src/ewcs_edge_detect.sv
// Purpose : synchronise the external interrupt pin and flag selected edges
// Assumes : pin is asynchronous to clock
// Notes   : three-stage sampler; change counts once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module ewcs_edge_detect (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       irq_pin,
  input  wire logic [1:0] edge_sel,
  output logic            edge_pulse
);

  logic [2:0] sync;
  logic       level;

  // three-flop sampler, first stage read only by second
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync <= 3'h0;
    end else begin
      sync <= {sync[1:0], irq_pin};
    end
  end

  // accepted level changes when stages two and three agree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      level <= 1'b0;
    end else if (sync[1] == sync[2]) begin
      level <= sync[2];
    end
  end

  // compare with previous accepted level and decode edge select
  always_comb begin
    edge_pulse = 1'b0;
    if (sync[1] == sync[2] && sync[2] != level) begin
      unique case (edge_sel)
        ewcs_pkg::EDGE_OFF:  edge_pulse = 1'b0;
        ewcs_pkg::EDGE_RISE: edge_pulse = sync[2];
        ewcs_pkg::EDGE_FALL: edge_pulse = !sync[2];
        ewcs_pkg::EDGE_BOTH: edge_pulse = 1'b1;
      endcase
    end
  end

endmodule // ewcs_edge_detect
`default_nettype wire

// ### src/ewcs_pkg.sv
// Purpose : shared constants and types for the edge/watchdog/clock-select register block
// Assumes : classic wishbone slave, 32-bit data, 100 MHz clock
// Notes   : register offsets are byte addresses of aligned words
// Contract
// - edge select 00 off, 01 rising, 10 falling, 11 both edges.
// - control bits 5 and 4 always read as zero.
// - enable code 1010 disables watchdog; any other code enables; 0101 recommended.
// - watchdog configuration option forces watchdog on, code ignored.
// - four clock sources: crystal, external rc, internal fast rc, 13kHz slow rc.
// - internal fast rc runs at 4, 8 or 12 MHz by selection.
// - watchdog clock source also follows the oscillator selection; here set by cfg.wdt_from_sysclk and cfg.slow_rc_off, not by clk_src.
// - source chosen from configuration options together with register settings; here the cfg.clk_src straps alone choose it.
// - crystal mode claims both oscillator pins from the port.
// - external rc uses only pin one (port a line six); line five stays port.
// - internal fast rc uses no pins; lines five and six are port lines.
// - sleep stops system clock; slow rc keeps running unless option disables it; here it runs only while it is the source or the watchdog is on.
// - power-up loads enable code 1010, so watchdog off unless option set.
package ewcs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;  // system_control_two
  localparam logic [3:0] ADDR_CFG    = 4'h4;  // clock / option status
  localparam logic [3:0] ADDR_IRQ_ST = 4'h8;  // sticky event status
  localparam logic [3:0] ADDR_IRQ_MK = 4'hc;  // event mask

  // ----------------------------------------------------------------
  // control field layout and reset
  // ----------------------------------------------------------------
  localparam int         EDGE_HI_POS  = 7;
  localparam int         EDGE_LO_POS  = 6;
  localparam int         WDT_CODE_MSB = 3;
  localparam logic [1:0] EDGE_RESET   = 2'h2;
  localparam logic [3:0] WDT_DISABLE  = 4'ha;
  localparam logic [3:0] WDT_RECOMMEND = 4'h5;
  localparam logic [7:0] CTRL_WMASK   = 8'hcf;

  // edge select encodings
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // event status bits
  localparam int EV_EXT_IRQ  = 0;
  localparam int EV_WDT_CHG  = 1;
  localparam int EV_WIDTH    = 2;
  localparam logic [1:0] EV_RESET = 2'h0;

  // ----------------------------------------------------------------
  // clock sources and fast rc frequencies
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EWCS_SRC_CRYSTAL,
    EWCS_SRC_EXT_RC,
    EWCS_SRC_FAST_RC,
    EWCS_SRC_SLOW_RC
  } ewcs_src_e;

  typedef enum logic [1:0] {
    EWCS_FRC_4MHZ,
    EWCS_FRC_8MHZ,
    EWCS_FRC_12MHZ
  } ewcs_frc_e;

  localparam int SLOW_RC_HZ = 13000;

  // configuration options, static straps
  typedef struct packed {
    ewcs_src_e  clk_src;
    ewcs_frc_e  fast_rc_freq;
    logic       wdt_force_on;
    logic       slow_rc_off;
    logic       wdt_from_sysclk;
  } ewcs_cfg_s;

  // oscillator pin ownership
  typedef struct packed {
    logic osc_pin_one_claimed;   // port_a_line_six used by oscillator
    logic osc_pin_two_claimed;   // port_a_line_five used by oscillator
  } ewcs_pins_s;

endpackage

// ### src/ewcs_top.sv
// Purpose : system control register block with edge select, watchdog gate, clock select
// Assumes : classic wishbone slave, single clock, synchronous active-low reset
// Notes   : unmapped addresses ack with zero data; writes there are ignored
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ewcs_top (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // configuration straps and status
  input  wire ewcs_pkg::ewcs_cfg_s  cfg,
  input  wire logic                 sleep,
  input  wire logic                 ext_irq_pin,
  // outputs
  output logic                      ext_irq_req,
  output logic                      watchdog_run,
  output logic                      irq,
  output ewcs_pkg::ewcs_pins_s      osc_pins,
  output logic                      sys_osc_run,
  output logic                      slow_rc_run,
  output logic                      wdt_clk_slow,
  output logic [1:0]                fast_rc_freq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0]                 edge_sel;
  logic [3:0]                 watchdog_enable_code;
  logic [ewcs_pkg::EV_WIDTH-1:0] ev_status;
  logic [ewcs_pkg::EV_WIDTH-1:0] ev_mask;
  logic [ewcs_pkg::EV_WIDTH-1:0] ev_set;
  logic                       edge_pulse;
  logic                       wdt_on;
  logic                       wdt_on_q;
  logic                       acc;
  logic                       wr;
  logic [7:0]                 ctrl_read;
  logic [7:0]                 cfg_read;
  logic [31:0]                next_dat;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // single-wait-state access: ack one cycle after request, dropped next cycle
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = acc && wb_we_i && wb_sel_i[0];

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // edge select and watchdog code, written through byte lane zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      edge_sel             <= ewcs_pkg::EDGE_RESET;
      watchdog_enable_code <= ewcs_pkg::WDT_DISABLE;
    end else if (wr && wb_adr_i == ewcs_pkg::ADDR_CTRL) begin
      edge_sel             <= wb_dat_i[ewcs_pkg::EDGE_HI_POS:ewcs_pkg::EDGE_LO_POS];
      watchdog_enable_code <= wb_dat_i[ewcs_pkg::WDT_CODE_MSB:0];
    end
  end

  // watchdog gate: option forces on, else code other than disable pattern
  assign wdt_on = cfg.wdt_force_on ||
                  (watchdog_enable_code != ewcs_pkg::WDT_DISABLE);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wdt_on_q     <= 1'b0;
      watchdog_run <= 1'b0;
    end else begin
      wdt_on_q     <= wdt_on;
      watchdog_run <= wdt_on;
    end
  end

  // unimplemented bits 5:4 read as zero
  assign ctrl_read = {edge_sel, 2'h0, watchdog_enable_code};
  assign cfg_read  = {1'b0, cfg.wdt_from_sysclk, cfg.slow_rc_off, cfg.wdt_force_on,
                      cfg.fast_rc_freq, cfg.clk_src};

  // ----------------------------------------------------------------
  // external interrupt edge detection
  // ----------------------------------------------------------------
  ewcs_edge_detect u_edge (
    .clock      (clock),
    .rst_n      (rst_n),
    .irq_pin    (ext_irq_pin),
    .edge_sel   (edge_sel),
    .edge_pulse (edge_pulse)
  );

  // one request pulse per selected edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_irq_req <= 1'b0;
    end else begin
      ext_irq_req <= edge_pulse;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  assign ev_set[ewcs_pkg::EV_EXT_IRQ] = edge_pulse;
  assign ev_set[ewcs_pkg::EV_WDT_CHG] = wdt_on != wdt_on_q;

  // sticky status, write one to clear, set wins over clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ev_status <= ewcs_pkg::EV_RESET;
    end else if (wr && wb_adr_i == ewcs_pkg::ADDR_IRQ_ST) begin
      ev_status <= (ev_status & ~wb_dat_i[ewcs_pkg::EV_WIDTH-1:0]) | ev_set;
    end else begin
      ev_status <= ev_status | ev_set;
    end
  end

  // mask register, one enables the bit
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ev_mask <= ewcs_pkg::EV_RESET;
    end else if (wr && wb_adr_i == ewcs_pkg::ADDR_IRQ_MK) begin
      ev_mask <= wb_dat_i[ewcs_pkg::EV_WIDTH-1:0];
    end
  end

  // level interrupt from registered status and mask
  assign irq = |(ev_status & ev_mask);

  // ----------------------------------------------------------------
  // clock source selection
  // ----------------------------------------------------------------
  ewcs_clock_select u_clk (
    .cfg          (cfg),
    .sleep        (sleep),
    .wdt_on       (wdt_on),
    .pins         (osc_pins),
    .sys_osc_run  (sys_osc_run),
    .slow_rc_run  (slow_rc_run),
    .wdt_clk_slow (wdt_clk_slow),
    .fast_rc_freq (fast_rc_freq)
  );

  // ----------------------------------------------------------------
  // read data and acknowledge
  // ----------------------------------------------------------------
  // read mux; unmapped addresses return zero
  always_comb begin
    next_dat = 32'h0;
    unique case (wb_adr_i)
      ewcs_pkg::ADDR_CTRL:   next_dat = {24'h0, ctrl_read};
      ewcs_pkg::ADDR_CFG:    next_dat = {24'h0, cfg_read};
      ewcs_pkg::ADDR_IRQ_ST: next_dat = {30'h0, ev_status};
      ewcs_pkg::ADDR_IRQ_MK: next_dat = {30'h0, ev_mask};
      default:               next_dat = 32'h0;
    endcase
  end

  // ack one cycle after request, data registered alongside
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? next_dat : 32'h0;
    end
  end

endmodule // ewcs_top
`default_nettype wire
